// ===== ccr_ctrl_regs.sv
`timescale 1ns/100ps
module ccr_ctrl_regs
    import ccr_pkg::*;
#(
    parameter bit FLOAT_VARIANT = 1'b0
)(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // control move port, side-b shift unit only
    input  wire logic        mv_wr,
    input  wire logic        mv_rd,
    input  wire logic [4:0]  mv_sel,
    input  wire logic [31:0] mv_wdata,
    output logic      [31:0] mv_rdata_r,
    // status events
    input  wire logic        sat_evt,
    input  wire logic        sat_cond_true,
    input  wire logic        irq_taken,
    input  wire logic [31:0] exec_pc,
    input  wire logic        exec_valid,
    input  wire logic        byte_order_pin,
    // memory paths
    input  wire logic [31:0] mem_data_a,
    input  wire logic [31:0] mem_data_b,
    input  wire logic [31:0] mem_data_x,
    input  wire logic [31:0] mem_data_y,
    input  wire logic        load_en,
    input  wire logic        dw_load,
    input  wire logic        addr_cross,
    input  wire logic        store_req,
    input  wire logic        long_read_req,
    input  wire logic [31:0] store_src_a,
    input  wire logic [31:0] store_src_b,
    input  wire logic [31:0] addr_calc_a,
    input  wire logic [31:0] addr_calc_b,
    output logic      [31:0] load_path_a_r,
    output logic      [31:0] load_path_b_r,
    output logic      [31:0] load_hi_a_r,
    output logic      [31:0] load_hi_b_r,
    output logic             dw_valid_r,
    output logic      [31:0] store_path_a_r,
    output logic      [31:0] store_path_b_r,
    output logic             store_grant_r,
    output logic             long_read_grant_r,
    output logic      [31:0] addr_path_a_r,
    output logic      [31:0] addr_path_b_r,
    // control outputs
    output logic      [15:0] ptr_mode_r,
    output logic      [4:0]  block_size_zero_r,
    output logic      [4:0]  block_size_one_r,
    output logic      [2:0]  program_cache_mode_r,
    output logic      [2:0]  data_cache_mode_r,
    output logic             global_irq_allow_r,
    output logic             clip_flag_r
);
    logic [31:0] mode_reg_r;
    logic        byte_order_bit_r;
    logic        prior_irq_allow_r;
    logic [31:0] execute_phase_pc_reg_r;
    logic [31:0] stat_view;
    logic        sat_pend_r;
    logic        wr_mode;
    logic        wr_stat;
    logic [7:0]  cpu_id;

    assign cpu_id  = FLOAT_VARIANT ? CCR_CPU_ID_FLT : CCR_CPU_ID_FIX;
    assign wr_mode = mv_wr && (mv_sel == CCR_SEL_MODE); // see R5 see R6
    assign wr_stat = mv_wr && (mv_sel == CCR_SEL_STAT);

    // addressing mode register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mode_reg_r <= CCR_MODE_RST; // see R10
        end else if (wr_mode) begin
            mode_reg_r <= mv_wdata & CCR_MODE_WMASK; // see R10 see R23
        end
    end

    // per-pointer mode fields
    genvar gi;
    generate
        for (gi = 0; gi < CCR_NUM_PTR; gi++) begin : g_mode
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    ptr_mode_r[gi*CCR_MODE_W +: CCR_MODE_W] <= CCR_MODE_LINEAR;
                end else begin
                    ptr_mode_r[gi*CCR_MODE_W +: CCR_MODE_W] <=
                        mode_reg_r[gi*CCR_MODE_W +: CCR_MODE_W]; // see R7 see R8
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            block_size_zero_r <= 5'h0;
            block_size_one_r  <= 5'h0;
        end else begin
            block_size_zero_r <= mode_reg_r[CCR_BSZ0_LSB +: CCR_BSZ_W]; // see R11
            block_size_one_r  <= mode_reg_r[CCR_BSZ1_LSB +: CCR_BSZ_W]; // see R11
        end
    end

    // saturation pipeline: one delay slot
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sat_pend_r <= 1'b0;
        end else begin
            sat_pend_r <= sat_evt && sat_cond_true; // see R16 see R17
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            clip_flag_r <= 1'b0;
        end else if (sat_pend_r) begin
            clip_flag_r <= 1'b1; // see R15 see R16
        end else if (wr_stat) begin
            clip_flag_r <= mv_wdata[CCR_CLIP_BIT] & clip_flag_r; // see R15
        end
    end

    // control status fields
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            program_cache_mode_r <= CCR_CACHE_RST;
            data_cache_mode_r    <= CCR_CACHE_RST;
        end else if (wr_stat) begin
            program_cache_mode_r <= mv_wdata[CCR_PCM_LSB +: 3]; // see R19
            data_cache_mode_r    <= mv_wdata[CCR_DCM_LSB +: 3]; // see R19
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            byte_order_bit_r <= 1'b0;
        end else begin
            byte_order_bit_r <= byte_order_pin; // see R18
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            global_irq_allow_r <= 1'b0;
            prior_irq_allow_r  <= 1'b0;
        end else if (irq_taken) begin
            prior_irq_allow_r  <= global_irq_allow_r; // see R20
            global_irq_allow_r <= 1'b0; // see R21
        end else if (wr_stat) begin
            prior_irq_allow_r  <= mv_wdata[CCR_PRIOR_BIT];
            global_irq_allow_r <= mv_wdata[CCR_GLOB_BIT]; // see R21
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            execute_phase_pc_reg_r <= CCR_PC_RST;
        end else if (exec_valid) begin
            execute_phase_pc_reg_r <= exec_pc; // see R22 see R23
        end
    end

    always_comb begin
        stat_view = 32'h0;
        stat_view[CCR_ID_LSB +: 8]  = cpu_id; // see R12
        stat_view[CCR_REV_LSB +: 8] = CCR_REV_ID; // see R13
        stat_view[CCR_PDN_LSB +: 6] = 6'h0; // see R14
        stat_view[CCR_CLIP_BIT]     = clip_flag_r;
        stat_view[CCR_ORDER_BIT]    = byte_order_bit_r;
        stat_view[CCR_PCM_LSB +: 3] = program_cache_mode_r;
        stat_view[CCR_DCM_LSB +: 3] = data_cache_mode_r;
        stat_view[CCR_PRIOR_BIT]    = prior_irq_allow_r;
        stat_view[CCR_GLOB_BIT]     = global_irq_allow_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mv_rdata_r <= 32'h0;
        end else if (mv_rd) begin
            unique case (mv_sel)
                CCR_SEL_MODE: mv_rdata_r <= mode_reg_r; // see R10
                CCR_SEL_STAT: mv_rdata_r <= stat_view;
                CCR_SEL_EPC:  mv_rdata_r <= execute_phase_pc_reg_r; // see R22
                default:     mv_rdata_r <= 32'h0;
            endcase
        end
    end

    // load paths
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            load_path_a_r <= 32'h0;
            load_path_b_r <= 32'h0;
        end else if (load_en) begin
            load_path_a_r <= mem_data_a; // see R1
            load_path_b_r <= mem_data_b; // see R1
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            load_hi_a_r <= 32'h0;
            load_hi_b_r <= 32'h0;
            dw_valid_r  <= 1'b0;
        end else begin
            dw_valid_r <= FLOAT_VARIANT && load_en && dw_load; // see R2
            if (FLOAT_VARIANT && load_en && dw_load) begin
                load_hi_a_r <= mem_data_x; // see R2
                load_hi_b_r <= mem_data_y; // see R2
            end
        end
    end

    // store and long read share one path, store first
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            store_grant_r     <= 1'b0;
            long_read_grant_r <= 1'b0;
            store_path_a_r    <= 32'h0;
            store_path_b_r    <= 32'h0;
        end else begin
            store_grant_r     <= store_req; // see R3
            long_read_grant_r <= long_read_req && !store_req; // see R3
            if (store_req) begin
                store_path_a_r <= store_src_a;
                store_path_b_r <= store_src_b;
            end
        end
    end

    ccr_path_mux u_addr (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .data_a  (addr_calc_a),
        .data_b  (addr_calc_b),
        .swap    (addr_cross), // see R4
        .en      (1'b1),
        .out_a_r (addr_path_a_r),
        .out_b_r (addr_path_b_r)
    );

    sequence sat_seen_s;
        sat_evt && sat_cond_true;
    endsequence

    sequence wait_slot_s;
        ##2 clip_flag_r;
    endsequence

    clip_delay_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R16
        sat_seen_s |-> wait_slot_s)
        else $error("clip flag not set after saturation");
    clip_false_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R17
        !clip_flag_r && !$past(sat_evt && sat_cond_true) && !sat_pend_r ##1 1'b1
        |-> !clip_flag_r)
        else $error("clip flag set without true saturation");
    clip_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R15
        $fell(clip_flag_r) |-> $past(wr_stat) && !$past(sat_pend_r))
        else $error("clip flag cleared without move");
    mode_read_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R10
        mv_rd && mv_sel == CCR_SEL_MODE |=> mv_rdata_r[31:26] == 6'h0)
        else $error("mode register reserved bits nonzero");
    pdn_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R14
        mv_rd && mv_sel == CCR_SEL_STAT |=> mv_rdata_r[15:10] == 6'h0
            && mv_rdata_r[31:24] == cpu_id)
        else $error("status id or power field wrong");
    prior_irq_allow_save_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R20
        irq_taken |=> prior_irq_allow_r == $past(global_irq_allow_r) && !global_irq_allow_r)
        else $error("prior enable not saved");
    share_excl_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R3
        !(store_grant_r && long_read_grant_r))
        else $error("store and long read both granted");
    addr_cross_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R4
        addr_cross |=> addr_path_a_r == $past(addr_calc_b))
        else $error("cross address not routed");
    load_a_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R1
        load_en |=> load_path_a_r == $past(mem_data_a) && load_path_b_r == $past(mem_data_b))
        else $error("load path mismatch");
    mode_fwd_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R7
        wr_mode |=> ##1 ptr_mode_r == $past(mv_wdata[15:0], 2))
        else $error("mode field not forwarded");
endmodule

// ===== ccr_pkg.sv
// Overview of operation
// R1: two 32-bit load paths, path a feeds file a, path b feeds file b.
// R2: floating variant adds load path so double load writes two registers each side.
// R3: store paths share hardware with long reads; both cannot run at once.
// R4: data address from one side may steer loads or stores of other side.
// R5: only the side-b shift unit reads and writes the control registers.
// R6: software reaches control registers only through the control move instruction.
// R7: addressing-mode register holds a 2-bit mode field per pointer a4-a7, b4-b7.
// R8: mode 00 linear, 01 circular size zero, 10 circular size one, 11 reserved.
// R9: software aligns each circular buffer on a boundary equal to its block size.
// R10: reset clears addressing-mode register; its reserved bits always read zero.
// R11: each block size is 5-bit n, giving length two to the n plus one bytes.
// R12: status bits 31-24 hold read-only cpu identification code.
// R13: status bits 23-16 hold read-only silicon revision code.
// R14: status bits 15-10 are the power-down field and always read zero.
// R15: clip flag set only by saturation, cleared only by a control move write.
// R16: set beats same-cycle clear; flag visible one full cycle after saturation.
// R17: a false conditional instruction leaves the clip flag unchanged.
// R18: status bit 8 reports byte order, 1 little endian, 0 big endian.
// R19: bits 7-5 program cache mode, bits 4-2 data cache mode, 3 bits each.
// R20: status bit 1 captures global interrupt enable whenever an interrupt is taken.
// R21: status bit 0 enables all maskable interrupts; reset and nmi unaffected.
// R22: execute-phase pc holds 32-bit address of the packet in first execute phase.
// R23: writes to execute-phase pc, id fields and reserved bits are ignored.
package ccr_pkg;
    localparam logic [4:0]  CCR_SEL_MODE    = 5'h00;
    localparam logic [4:0]  CCR_SEL_STAT    = 5'h01;
    localparam logic [4:0]  CCR_SEL_EPC     = 5'h10;
    localparam int          CCR_NUM_PTR     = 8;
    localparam int          CCR_MODE_W      = 2;
    localparam int          CCR_BSZ0_LSB    = 16;
    localparam int          CCR_BSZ1_LSB    = 21;
    localparam int          CCR_BSZ_W       = 5;
    localparam logic [31:0] CCR_MODE_RST    = 32'h0000_0000;
    localparam logic [31:0] CCR_MODE_WMASK  = 32'h03ff_ffff;
    localparam int          CCR_ID_LSB      = 24;
    localparam int          CCR_REV_LSB     = 16;
    localparam int          CCR_PDN_LSB     = 10;
    localparam int          CCR_CLIP_BIT    = 9;
    localparam int          CCR_ORDER_BIT   = 8;
    localparam int          CCR_PCM_LSB     = 5;
    localparam int          CCR_DCM_LSB     = 2;
    localparam int          CCR_PRIOR_BIT   = 1;
    localparam int          CCR_GLOB_BIT    = 0;
    localparam logic [7:0]  CCR_CPU_ID_FIX  = 8'h5a; // arbitrary value
    localparam logic [7:0]  CCR_CPU_ID_FLT  = 8'ha5; // arbitrary value
    localparam logic [7:0]  CCR_REV_ID      = 8'h01; // arbitrary value
    localparam logic [2:0]  CCR_CACHE_RST   = 3'h0;
    localparam logic [31:0] CCR_PC_RST      = 32'h0000_0000;
    typedef enum logic [1:0] {
        CCR_MODE_LINEAR = 2'h0,
        CCR_MODE_CIRC0  = 2'h1,
        CCR_MODE_CIRC1  = 2'h2,
        CCR_MODE_RSVD   = 2'h3
    } ccr_mode_type;
endpackage

// ===== ccr_path_mux.sv
`timescale 1ns/100ps
module ccr_path_mux
    import ccr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [31:0] data_a,
    input  wire logic [31:0] data_b,
    input  wire logic        swap,
    input  wire logic        en,
    output logic      [31:0] out_a_r,
    output logic      [31:0] out_b_r
);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            out_a_r <= 32'h0;
            out_b_r <= 32'h0;
        end else if (en) begin
            out_a_r <= swap ? data_b : data_a;
            out_b_r <= swap ? data_a : data_b;
        end
    end
endmodule

// ===== ccr_unit_model.sv
`timescale 1ns/100ps
module ccr_unit_model
    import ccr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic [31:0] mv_rdata_r,
    output logic             mv_wr,
    output logic             mv_rd,
    output logic      [4:0]  mv_sel,
    output logic      [31:0] mv_wdata,
    output logic             sat_evt,
    output logic             sat_cond_true,
    output logic             irq_taken
);
    initial begin
        mv_wr         = 1'b0;
        mv_rd         = 1'b0;
        mv_sel        = 5'h00;
        mv_wdata      = 32'h0;
        sat_evt       = 1'b0;
        sat_cond_true = 1'b0;
        irq_taken     = 1'b0;
    end
    // one move per cycle, launched at the falling edge, data scrambled after
    task automatic move(input logic wr, input logic [4:0] sel, input logic [31:0] d);
        mv_wr    = wr;
        mv_rd    = ~wr;
        mv_sel   = sel;
        mv_wdata = d;
        @(negedge clk_sys);
        mv_wr    = 1'b0;
        mv_rd    = 1'b0;
        mv_sel   = ~sel;
        mv_wdata = ~d;
    endtask
    task automatic fetch(input logic [4:0] sel, output logic [31:0] d);
        move(1'b0, sel, 32'h0);
        @(negedge clk_sys);
        d = mv_rdata_r;
    endtask
    task automatic raise(input logic clip_flag, input logic cond, input logic irq);
        sat_evt       = clip_flag;
        sat_cond_true = cond;
        irq_taken     = irq;
    endtask
endmodule

// ===== cpu_control_register_file_tb.sv
`timescale 1ns/100ps
module cpu_control_register_file_tb;
    import ccr_pkg::*;
    logic        clk_sys, rstn, mv_wr, mv_rd, sat_evt, sat_cond_true, irq_taken;
    logic        exec_valid, byte_order_pin, load_en, addr_cross, store_req, long_read_req;
    logic        st_g, lr_g, irq_en, clip;
    logic [4:0]  mv_sel, bsz0, bsz1;
    logic [2:0]  pcm, dcm;
    logic [15:0] ptr_mode;
    logic [31:0] mv_wdata, mv_rdata_r, exec_pc, mem_a, mem_b, src_a, src_b, acal_a, acal_b;
    logic [31:0] ld_a, ld_b, st_a, st_b, ad_a, ad_b;
    int          mismatches, n_compared;

    ccr_unit_model ccr_unit_model_i (.clk_sys(clk_sys), .mv_rdata_r(mv_rdata_r), .mv_wr(mv_wr),
        .mv_rd(mv_rd), .mv_sel(mv_sel), .mv_wdata(mv_wdata), .sat_evt(sat_evt),
        .sat_cond_true(sat_cond_true), .irq_taken(irq_taken));
    ccr_ctrl_regs #(.FLOAT_VARIANT(1'b0)) ccr_ctrl_regs_i (.clk_sys(clk_sys), .rstn(rstn),
        .mv_wr(mv_wr), .mv_rd(mv_rd), .mv_sel(mv_sel), .mv_wdata(mv_wdata),
        .mv_rdata_r(mv_rdata_r), .sat_evt(sat_evt), .sat_cond_true(sat_cond_true),
        .irq_taken(irq_taken), .exec_pc(exec_pc), .exec_valid(exec_valid),
        .byte_order_pin(byte_order_pin), .mem_data_a(mem_a), .mem_data_b(mem_b),
        .mem_data_x(32'h0), .mem_data_y(32'h0), .load_en(load_en), .dw_load(1'b0),
        .addr_cross(addr_cross), .store_req(store_req), .long_read_req(long_read_req),
        .store_src_a(src_a), .store_src_b(src_b), .addr_calc_a(acal_a), .addr_calc_b(acal_b),
        .load_path_a_r(ld_a), .load_path_b_r(ld_b), .load_hi_a_r(), .load_hi_b_r(),
        .dw_valid_r(), .store_path_a_r(st_a), .store_path_b_r(st_b), .store_grant_r(st_g),
        .long_read_grant_r(lr_g), .addr_path_a_r(ad_a), .addr_path_b_r(ad_b),
        .ptr_mode_r(ptr_mode), .block_size_zero_r(bsz0), .block_size_one_r(bsz1),
        .program_cache_mode_r(pcm), .data_cache_mode_r(dcm), .global_irq_allow_r(irq_en),
        .clip_flag_r(clip));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rdchk(input string name, input logic [4:0] sel, input logic [31:0] exp);
        logic [31:0] d;
        ccr_unit_model_i.fetch(sel, d);
        check(name, d, exp);
    endtask
    task automatic wr(input logic [4:0] sel, input logic [31:0] d);
        ccr_unit_model_i.move(1'b1, sel, d);
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic mode_test;
        rdchk("mode_reset", CCR_SEL_MODE, 32'h0);
        // no buffer is placed, so alignment holds trivially
        wr(CCR_SEL_MODE, 32'hfd2a_e4e4);
        tick(2);
        check("ptr_mode", {16'h0, ptr_mode}, 32'h0000_e4e4);
        check("bsz0", {27'h0, bsz0}, 32'h0000_000a);
        check("bsz1", {27'h0, bsz1}, 32'h0000_0009);
        rdchk("mode_rd", CCR_SEL_MODE, 32'h012a_e4e4);
        wr(CCR_SEL_MODE, 32'hffff_ffff);
        rdchk("mode_ones", CCR_SEL_MODE, 32'h03ff_ffff);
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(1);
        rdchk("mode_rst2", CCR_SEL_MODE, 32'h0);
        check("ptr_rst2", {16'h0, ptr_mode}, 32'h0);
    endtask
    task automatic stat_test;
        wr(CCR_SEL_STAT, 32'hffff_fdff);
        rdchk("stat_rd", CCR_SEL_STAT, {CCR_CPU_ID_FIX, CCR_REV_ID, 16'h01ff});
        check("cache_modes", {26'h0, pcm, dcm}, 32'h0000_003f);
        check("irq_en", {31'h0, irq_en}, 32'h1);
        byte_order_pin = 1'b0;
        tick(2);
        rdchk("stat_be", CCR_SEL_STAT, {CCR_CPU_ID_FIX, CCR_REV_ID, 16'h00ff});
        ccr_unit_model_i.raise(1'b0, 1'b0, 1'b1);
        tick(1);
        ccr_unit_model_i.raise(1'b0, 1'b0, 1'b0);
        tick(1);
        rdchk("stat_irq", CCR_SEL_STAT, {CCR_CPU_ID_FIX, CCR_REV_ID, 16'h00fe});
        check("irq_en_irq", {31'h0, irq_en}, 32'h0);
    endtask
    task automatic clip_test;
        wr(CCR_SEL_STAT, 32'h0);
        ccr_unit_model_i.raise(1'b1, 1'b0, 1'b0);
        tick(1);
        ccr_unit_model_i.raise(1'b0, 1'b0, 1'b0);
        tick(3);
        check("clip_false", {31'h0, clip}, 32'h0);
        ccr_unit_model_i.raise(1'b1, 1'b1, 1'b0);
        tick(1);
        check("clip_early", {31'h0, clip}, 32'h0);
        ccr_unit_model_i.raise(1'b0, 1'b0, 1'b0);
        tick(1);
        check("clip_set", {31'h0, clip}, 32'h1);
        rdchk("stat_clip", CCR_SEL_STAT, {CCR_CPU_ID_FIX, CCR_REV_ID, 16'h0200});
        // clear lands in the cycle the pending set reaches the flag
        ccr_unit_model_i.raise(1'b1, 1'b1, 1'b0);
        tick(1);
        ccr_unit_model_i.raise(1'b0, 1'b0, 1'b0);
        wr(CCR_SEL_STAT, 32'h0);
        check("clip_wins", {31'h0, clip}, 32'h1);
        tick(1);
        check("clip_held", {31'h0, clip}, 32'h1);
        wr(CCR_SEL_STAT, 32'h0);
        tick(1);
        check("clip_clr", {31'h0, clip}, 32'h0);
        wr(CCR_SEL_STAT, 32'h0000_0200);
        tick(1);
        check("clip_wr1", {31'h0, clip}, 32'h0);
    endtask
    task automatic pc_paths_test;
        tick(2);
        rdchk("pc", CCR_SEL_EPC, 32'h1234_5678);
        wr(CCR_SEL_EPC, 32'h0);
        rdchk("pc_wr", CCR_SEL_EPC, 32'h1234_5678);
        rdchk("unmapped", 5'h02, 32'h0);
        load_en = 1'b1;
        addr_cross = 1'b1;
        store_req = 1'b1;
        long_read_req = 1'b1;
        tick(1);
        check("load_a", ld_a, 32'h1111_0001);
        check("load_b", ld_b, 32'h2222_0002);
        check("addr_a", ad_a, 32'h0000_2000);
        check("addr_b", ad_b, 32'h0000_1000);
        check("store_a", st_a, 32'hcafe_0001);
        check("store_b", st_b, 32'hbeef_0002);
        check("grants", {30'h0, st_g, lr_g}, 32'h2);
        store_req = 1'b0;
        tick(1);
        check("grants_lr", {30'h0, st_g, lr_g}, 32'h1);
    endtask

    initial begin
        mismatches = 0;
        n_compared = 0;
        rstn = 1'b0;
        byte_order_pin = 1'b1;
        exec_pc = 32'h1234_5678;
        exec_valid = 1'b1;
        mem_a = 32'h1111_0001;
        mem_b = 32'h2222_0002;
        src_a = 32'hcafe_0001;
        src_b = 32'hbeef_0002;
        acal_a = 32'h0000_1000;
        acal_b = 32'h0000_2000;
        {load_en, addr_cross, store_req, long_read_req} = 4'h0;
        tick(16);
        rstn = 1'b1;
        mode_test();
        stat_test();
        clip_test();
        pc_paths_test();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
endmodule
